// ==== include/ssa_pkg.sv ====
/*
 * Constants and types for the spindle and actuator supervisor.
 * Assumes a 50 MHz system clock; all system-clock counts derive from it.
 */
package ssa_pkg;
    // *************************************************************
    // Clock and timing
    // *************************************************************
    localparam int CLK_HZ = 50000000;
    localparam int REF_REG_HZ = 360;
    localparam int REF_CHK_HZ = 92100;
    localparam int NOM_RPM = 3600;
    // Nominal index period in system clocks (one index per revolution).
    localparam int IDX_NOM_CYC = (CLK_HZ / NOM_RPM) * 60;
    // One percent window, floor for the wide edge, ceiling for the narrow edge.
    localparam int IDX_LO_CYC = (IDX_NOM_CYC * 99 + 99) / 100;
    localparam int IDX_HI_CYC = (IDX_NOM_CYC * 101) / 100;
    // Reference divider counts: half period for 360 Hz, full period for 92.1 kHz.
    localparam int REG_HALF_CYC = CLK_HZ / (2 * REF_REG_HZ);
    localparam int CHK_DIV_CYC = CLK_HZ / REF_CHK_HZ;
    // Nominal 92.1 kHz ticks per revolution and its 1 percent window.
    localparam int CHK_NOM = (REF_CHK_HZ * 60) / NOM_RPM;
    localparam int CHK_LO = (CHK_NOM * 99) / 100;
    localparam int CHK_HI = (CHK_NOM * 101 + 99) / 100;
    // Regulator tolerance: 3.6 rpm of 3600 is 1/1000 of the revolution period.
    localparam int REG_TOL_CYC = IDX_NOM_CYC / 1000;
    localparam int CNT_W = 24;

    // *************************************************************
    // Registers
    // *************************************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_IRQ = 8'h08;
    localparam logic [7:0] ADR_MASK = 8'h0c;
    localparam logic [7:0] ADR_VEL = 8'h10;
    localparam logic [7:0] ADR_TRK = 8'h14;
    // Control bits.
    localparam int C_HALT = 0;
    localparam int C_SEEK = 1;
    localparam int C_EVEN = 2;
    localparam int C_ODD = 3;
    localparam int C_PWR = 4;
    localparam int C_DIR = 5;
    localparam int C_CLRTRK = 6;
    localparam logic [6:0] CTRL_RST = 7'h00;
    // Interrupt bits.
    localparam int I_FAULT = 0;
    localparam int I_SPEED = 1;
    localparam int I_TRK0 = 2;
    localparam int I_XING = 3;
    localparam int NIRQ = 4;

    // *************************************************************
    // Spindle sequencer states
    // *************************************************************
    typedef enum logic [1:0] {
        SP_SPIN = 2'b00,
        SP_REG = 2'b01,
        SP_RUN = 2'b11,
        SP_STOP = 2'b10
    } ssa_sp_t;
endpackage

// ==== core/ssa_supervisor.sv ====
/*
 * Spindle and actuator supervisor: commutation, speed regulation, speed check,
 * brake, actuator lock, mode switch, velocity command, track counting.
 * Assumes pins from the drive are asynchronous and a Wishbone classic master.
 */
// The Wishbone register port and the address map are this design's own decisions.
// Operation
// - After power-on the lock release is driven only once speed-ok has been seen.
// - The three Hall inputs select which of the three phase outputs is driven.
// - With regulation on, Hall edges are locked to 360 Hz to hold 3600 rpm +-3.6 rpm.
// - After reset release the halt output is false and regulation is off to spin up.
// - Index intervals within one percent of 3600 rpm turn regulation on.
// - Stopping drives the halt output to both speed control and brake relay.
// - A checker counts 92.1 kHz ticks per index giving speed-ok and count-invalid.
// - Speed-ok lost or count-invalid while running shuts drive operation down.
// - While halted the brake is applied and all three phase drives are off.
// - The 1100 kHz marker detection is reported on the active-low track-zero output.
// - The seek output level selects seek or track-follow mode.
// - In seek mode an 8-bit velocity command is driven to the converter.
// - An even-track polarity select sets the position-error slope polarity.
// - An odd-track polarity select sets the current inverter gain sign.
// - Each on-peak pulse during a seek counts as one track crossing.
// - The power amplifier enable is driven only when allowed.
`timescale 1ns/1ns
module ssa_supervisor
    import ssa_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    // Spindle pins.
    input wire logic [2:0] hallIn,
    input wire logic indexIn,
    output logic [2:0] phaseDrive,
    output logic spindleHalt,
    output logic brakeRelay,
    output logic lockRelease,
    // Actuator pins.
    input wire logic trackZeroIn,
    input wire logic onPeakIn,
    output logic seekMode,
    output logic [7:0] velocityCmd,
    output logic evenPolarity,
    output logic oddPolarity,
    output logic servoEnable,
    output logic track_zero_out_n
);
    // *************************************************************
    // Synchronisers
    // *************************************************************
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    logic [5:0] prev_ff;
    logic [2:0] hallS;
    logic idxS;
    logic trk0S;
    logic peakS;
    logic idxRise;
    logic peakRise;
    logic hallEdge;

    // Two stages on each pin; the first stage feeds only the second.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_ff <= 6'h00;
            sync2_ff <= 6'h00;
            prev_ff <= 6'h00;
        end else begin
            sync1_ff <= {onPeakIn, trackZeroIn, indexIn, hallIn};
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end
    assign hallS = sync2_ff[2:0];
    assign idxS = sync2_ff[3];
    assign trk0S = sync2_ff[4];
    assign peakS = sync2_ff[5];
    assign idxRise = idxS & ~prev_ff[3];
    assign peakRise = peakS & ~prev_ff[5];
    assign hallEdge = hallS[0] & ~prev_ff[0];

    // *************************************************************
    // Control registers
    // *************************************************************
    logic [6:0] ctrl_ff;
    logic [NIRQ-1:0] irqStat_ff;
    logic [NIRQ-1:0] irqMask_ff;
    logic [7:0] vel_ff;
    logic [15:0] trk_ff;
    logic speedOk_ff;
    logic cntInvalid_ff;
    logic regOn_ff;
    logic fault_ff;
    logic lock_ff;
    ssa_sp_t sp_ff;
    logic wbWr;
    logic wbRd;
    logic [NIRQ-1:0] evt;

    assign wbWr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    assign wbRd = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // Software control word; clear-track bit is a self-clearing strobe.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_ff <= CTRL_RST;
            vel_ff <= 8'h00;
            irqMask_ff <= '0;
        end else begin
            ctrl_ff[C_CLRTRK] <= 1'b0;
            if (wbWr && wb_adr_i == ADR_CTRL) begin
                ctrl_ff <= wb_dat_i[6:0];
            end
            if (wbWr && wb_adr_i == ADR_VEL) begin
                vel_ff <= wb_dat_i[7:0];
            end
            if (wbWr && wb_adr_i == ADR_MASK) begin
                irqMask_ff <= wb_dat_i[NIRQ-1:0];
            end
        end
    end

    // Sticky events; a set in the clearing cycle wins.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqStat_ff <= '0;
        end else begin
            irqStat_ff <= (irqStat_ff & ~((wbWr && wb_adr_i == ADR_IRQ) ?
                          wb_dat_i[NIRQ-1:0] : {NIRQ{1'b0}})) | evt;
        end
    end

    // Bus answer one cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wbRd;
            unique case (wb_adr_i)
                ADR_CTRL: wb_dat_o <= {25'h0, ctrl_ff};
                ADR_STAT: wb_dat_o <= {24'h0, 1'b0, trk0S, lock_ff, fault_ff,
                                       regOn_ff, cntInvalid_ff, speedOk_ff, spindleHalt};
                ADR_IRQ: wb_dat_o <= {28'h0, irqStat_ff};
                ADR_MASK: wb_dat_o <= {28'h0, irqMask_ff};
                ADR_VEL: wb_dat_o <= {24'h0, vel_ff};
                ADR_TRK: wb_dat_o <= {16'h0, trk_ff};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end

    // *************************************************************
    // Speed checker on the 92.1 kHz reference
    // *************************************************************
    logic [11:0] chkDiv_ff;
    logic [11:0] chkCnt_ff;
    logic chkTick;
    assign chkTick = (chkDiv_ff == 12'(CHK_DIV_CYC - 1));

    // Counts reference ticks between index pulses and grades the result.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chkDiv_ff <= 12'h000;
            chkCnt_ff <= 12'h000;
            speedOk_ff <= 1'b0;
            cntInvalid_ff <= 1'b1;
        end else begin
            chkDiv_ff <= chkTick ? 12'h000 : chkDiv_ff + 12'h001;
            if (idxRise) begin
                chkCnt_ff <= 12'h000;
                cntInvalid_ff <= 1'b0;
                speedOk_ff <= (chkCnt_ff >= 12'(CHK_LO)) && (chkCnt_ff <= 12'(CHK_HI));
            end else if (chkTick) begin
                if (chkCnt_ff == 12'hfff) begin
                    cntInvalid_ff <= 1'b1;
                    speedOk_ff <= 1'b0;
                end else begin
                    chkCnt_ff <= chkCnt_ff + 12'h001;
                end
            end
        end
    end

    // *************************************************************
    // Index interval timer and spindle sequencer
    // *************************************************************
    logic [CNT_W-1:0] idxCnt_ff;
    logic inWindow;
    assign inWindow = (idxCnt_ff >= CNT_W'(IDX_LO_CYC)) && (idxCnt_ff <= CNT_W'(IDX_HI_CYC));

    // Measures index-to-index time in system clocks.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            idxCnt_ff <= '0;
        end else if (idxRise) begin
            idxCnt_ff <= '0;
        end else if (idxCnt_ff != {CNT_W{1'b1}}) begin
            idxCnt_ff <= idxCnt_ff + CNT_W'(1);
        end
    end

    // Spin up, regulate, run, stop.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sp_ff <= SP_SPIN;
            regOn_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else if (ctrl_ff[C_HALT]) begin
            sp_ff <= SP_STOP;
            regOn_ff <= 1'b0;
        end else begin
            unique case (sp_ff)
                SP_SPIN: begin
                    regOn_ff <= 1'b0;
                    if (idxRise && inWindow) begin
                        sp_ff <= SP_REG;
                        regOn_ff <= 1'b1;
                    end
                end
                SP_REG: begin
                    if (speedOk_ff) begin
                        sp_ff <= SP_RUN;
                    end
                end
                SP_RUN: begin
                    if (!speedOk_ff || cntInvalid_ff) begin
                        sp_ff <= SP_STOP;
                        fault_ff <= 1'b1;
                        regOn_ff <= 1'b0;
                    end
                end
                SP_STOP: begin
                    sp_ff <= SP_SPIN;
                    fault_ff <= 1'b0;
                end
            endcase
        end
    end

    // *************************************************************
    // Regulator and commutation
    // *************************************************************
    logic [CNT_W-1:0] refCnt_ff;
    logic refPhase_ff;
    logic [1:0] duty_ff;
    logic [1:0] pwm_ff;
    logic [2:0] commute;

    // 360 Hz reference; hall phase versus reference raises or trims drive.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            refCnt_ff <= '0;
            refPhase_ff <= 1'b0;
            duty_ff <= 2'h3;
            pwm_ff <= 2'h0;
        end else begin
            pwm_ff <= pwm_ff + 2'h1;
            if (refCnt_ff == CNT_W'(REG_HALF_CYC - 1)) begin
                refCnt_ff <= '0;
                refPhase_ff <= ~refPhase_ff;
            end else begin
                refCnt_ff <= refCnt_ff + CNT_W'(1);
            end
            if (!regOn_ff) begin
                duty_ff <= 2'h3;
            end else if (hallEdge) begin
                // Hall leading the reference means too fast.
                if (refPhase_ff && duty_ff != 2'h1) begin
                    duty_ff <= duty_ff - 2'h1;
                end else if (!refPhase_ff && duty_ff != 2'h3) begin
                    duty_ff <= duty_ff + 2'h1;
                end
            end
        end
    end

    // Six-step table; illegal codes drive nothing.
    always_comb begin
        unique case (hallS)
            3'b001: commute = 3'b001;
            3'b011: commute = 3'b010;
            3'b010: commute = 3'b010;
            3'b110: commute = 3'b100;
            3'b100: commute = 3'b100;
            3'b101: commute = 3'b001;
            default: commute = 3'b000;
        endcase
    end

    // *************************************************************
    // Spindle and actuator outputs
    // *************************************************************
    // Lock releases once speed-ok is seen, then holds until a stop.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lock_ff <= 1'b0;
        end else if (sp_ff == SP_STOP) begin
            lock_ff <= 1'b0;
        end else if (speedOk_ff) begin
            lock_ff <= 1'b1;
        end
    end

    // Registered pin drive.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phaseDrive <= 3'h0;
            spindleHalt <= 1'b0;
            brakeRelay <= 1'b0;
            lockRelease <= 1'b0;
            seekMode <= 1'b0;
            velocityCmd <= 8'h00;
            evenPolarity <= 1'b0;
            oddPolarity <= 1'b0;
            servoEnable <= 1'b0;
            track_zero_out_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            spindleHalt <= (sp_ff == SP_STOP) | ctrl_ff[C_HALT];
            brakeRelay <= (sp_ff == SP_STOP) | ctrl_ff[C_HALT];
            phaseDrive <= ((sp_ff == SP_STOP) | ctrl_ff[C_HALT] | (pwm_ff >= duty_ff)) ?
                          3'h0 : commute;
            lockRelease <= lock_ff;
            seekMode <= ctrl_ff[C_SEEK];
            velocityCmd <= ctrl_ff[C_SEEK] ? vel_ff : 8'h00;
            evenPolarity <= ctrl_ff[C_EVEN];
            oddPolarity <= ctrl_ff[C_ODD];
            servoEnable <= ctrl_ff[C_PWR] & lock_ff & ~fault_ff;
            track_zero_out_n <= ~trk0S;
            irq <= |(irqStat_ff & irqMask_ff);
        end
    end

    // Track crossing counter, direction from control.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trk_ff <= 16'h0000;
        end else if (ctrl_ff[C_CLRTRK]) begin
            trk_ff <= 16'h0000;
        end else if (peakRise && ctrl_ff[C_SEEK]) begin
            trk_ff <= ctrl_ff[C_DIR] ? trk_ff - 16'h0001 : trk_ff + 16'h0001;
        end
    end

    assign evt[I_FAULT] = (sp_ff == SP_RUN) & (~speedOk_ff | cntInvalid_ff);
    assign evt[I_SPEED] = (sp_ff == SP_SPIN) & idxRise & inWindow;
    assign evt[I_TRK0] = trk0S & ~prev_ff[4];
    assign evt[I_XING] = peakRise & ctrl_ff[C_SEEK];
endmodule

// ==== verification/ssa_supervisor_properties.sv ====
/*
 * Concurrent checks on the supervisor's ports, bound into every instance.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module ssa_supervisor_checker (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Bus handshake.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Watched pins.
    input wire logic [2:0] phaseDrive,
    input wire logic spindleHalt,
    input wire logic brakeRelay,
    input wire logic lockRelease,
    input wire logic trackZeroIn,
    input wire logic seekMode,
    input wire logic [7:0] velocityCmd,
    input wire logic servoEnable,
    input wire logic track_zero_out_n
);
    // ************************************************************
    // Properties
    // ************************************************************
    // All checks share the system clock and are quiet during reset.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_reset_outputs_low: assert property ($past(rst) |-> !spindleHalt && !lockRelease)
        else $error("halt or lock active right after reset");
    a_halt_brake_pair: assert property (spindleHalt |-> brakeRelay)
        else $error("halt without brake relay");
    a_halt_no_phase: assert property (spindleHalt |-> phaseDrive == 3'h0)
        else $error("phase driven while halted");
    a_phase_one_hot: assert property ($onehot0(phaseDrive))
        else $error("more than one phase driven");
    a_servo_needs_lock: assert property (servoEnable |-> lockRelease)
        else $error("servo enabled with actuator locked");
    a_vel_only_seek: assert property (!seekMode |-> velocityCmd == 8'h00)
        else $error("velocity command outside seek");
    a_trk0_follow: assert property (track_zero_out_n == !$past(trackZeroIn, 3))
        else $error("track zero output does not follow marker");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
endmodule

bind ssa_supervisor ssa_supervisor_checker u_chk (.clk_sys(clk_sys), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .phaseDrive(phaseDrive),
    .spindleHalt(spindleHalt), .brakeRelay(brakeRelay), .lockRelease(lockRelease),
    .trackZeroIn(trackZeroIn), .seekMode(seekMode), .velocityCmd(velocityCmd),
    .servoEnable(servoEnable), .track_zero_out_n(track_zero_out_n));

// ==== verification/ssa_drive_model.sv ====
/*
 * Behavioural spindle motor and servo front end facing the supervisor.
 * Assumes the bench requests crossing pulses and the track-zero marker.
 */
`timescale 1ns/1ns
module ssa_drive_model #(
    parameter int HALL_GAP = 50
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Drive from the supervisor.
    input wire logic [2:0] phaseDrive,
    input wire logic brakeRelay,
    // Bench requests.
    input wire logic peakReq,
    input wire logic trkZeroReq,
    // Sensor pins back to the supervisor.
    output logic [2:0] hallIn,
    output logic indexIn,
    output logic onPeakIn,
    output logic trackZeroIn
);
    // ************************************************************
    // Rotor and servo sensors
    // ************************************************************
    logic [2:0] step_ff;
    int gap_ff;
    int peak_ff;

    // The rotor only turns while a phase is driven and the brake is off.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            step_ff <= 3'h0;
            gap_ff <= 0;
        end else if (phaseDrive != 3'h0 && !brakeRelay) begin
            gap_ff <= (gap_ff == HALL_GAP - 1) ? 0 : gap_ff + 1;
            if (gap_ff == HALL_GAP - 1) begin
                step_ff <= (step_ff == 3'h5) ? 3'h0 : step_ff + 3'h1;
            end
        end
    end

    // Six-step Hall code; index sits at the start of step zero.
    always_comb begin
        case (step_ff)
            3'h0: hallIn = 3'b001;
            3'h1: hallIn = 3'b011;
            3'h2: hallIn = 3'b010;
            3'h3: hallIn = 3'b110;
            3'h4: hallIn = 3'b100;
            default: hallIn = 3'b101;
        endcase
    end
    assign indexIn = (step_ff == 3'h0) && (gap_ff > 0) && (gap_ff < 5);

    // A crossing request becomes a three-cycle detector pulse.
    always_ff @(posedge clk_sys) begin
        if (peakReq) begin
            peak_ff <= 3;
        end else if (peak_ff != 0) begin
            peak_ff <= peak_ff - 1;
        end
        trackZeroIn <= trkZeroReq;
    end
    assign onPeakIn = (peak_ff != 0);
endmodule

// ==== verification/test_spindle_actuator_supervisor.sv ====
/*
 * Self-checking bench: bus reads, spindle halt, actuator mode and tracks.
 * Assumes the drive model and checker are compiled before this file.
 */
`timescale 1ns/1ns
module test_spindle_actuator_supervisor;
    import ssa_pkg::*;
    // ************************************************************
    // Signals and design
    // ************************************************************
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] msk;
    } ssa_note_t;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, peakReq = 1'b0, trkZeroReq = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, datOut, v, c;
    logic ack, irq, spindleHalt, brakeRelay, lockRelease, seekMode, evenPolarity;
    logic oddPolarity, servoEnable, trkZeroOutN, indexIn, trackZeroIn, onPeakIn;
    logic [2:0] hallIn, phaseDrive;
    logic [7:0] velocityCmd;
    ssa_note_t notes[$];
    ssa_note_t cur;
    int mismatches = 0, testsRun = 0, n;

    // Clock at 50 MHz.
    always #10 clk_sys = ~clk_sys;

    ssa_supervisor uut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(datOut),
        .wb_ack_o(ack), .irq(irq), .hallIn(hallIn), .indexIn(indexIn), .phaseDrive(phaseDrive),
        .spindleHalt(spindleHalt), .brakeRelay(brakeRelay), .lockRelease(lockRelease),
        .trackZeroIn(trackZeroIn), .onPeakIn(onPeakIn), .seekMode(seekMode),
        .velocityCmd(velocityCmd), .evenPolarity(evenPolarity), .oddPolarity(oddPolarity),
        .servoEnable(servoEnable), .track_zero_out_n(trkZeroOutN));
    ssa_drive_model #(.HALL_GAP(50)) drv (.clk_sys(clk_sys), .rst(rst), .phaseDrive(phaseDrive),
        .brakeRelay(brakeRelay), .peakReq(peakReq), .trkZeroReq(trkZeroReq), .hallIn(hallIn),
        .indexIn(indexIn), .onPeakIn(onPeakIn), .trackZeroIn(trackZeroIn));

    // ************************************************************
    // Tasks
    // ************************************************************
    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Reports the counts, prints the verdict and stops.
    task automatic end_sim();
        $display("Checks run %0d, mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // One classic cycle, held until ack is sampled high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        // Only the watchdog ends a wait for the answer.
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{e, m});
        xfer(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // Asks the model for one track-crossing pulse.
    task automatic peak();
        @(posedge clk_sys);
        peakReq <= 1'b1;
        @(posedge clk_sys);
        peakReq <= 1'b0;
        wt(8);
    endtask

    // Read answers are matched against the oldest noted expectation.
    always @(posedge clk_sys) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (notes.size() == 0) begin
                chk(32'h1, 32'h0, "unexpected read");
            end else begin
                cur = notes.pop_front();
                chk(datOut & cur.msk, cur.exp & cur.msk, "read data");
            end
        end
    end

    // Watchdog cuts a hang short.
    initial begin
        wt(20000);
        mismatches++;
        $display("ERROR at %0t: watchdog expired", $time);
        end_sim();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        v = $urandom(32'h4f7cd7d5);
        wt(20);
        rst <= 1'b0;
        wt(2);
        chk(32'({spindleHalt, brakeRelay, lockRelease, servoEnable, trkZeroOutN, irq}), 32'h2,
            "reset pins");
        for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0, (i == 1) ? 32'hfffffffb : '1);
        wr(ADR_CTRL, 32'h1 << C_HALT);
        wt(4);
        chk(32'({spindleHalt, brakeRelay, phaseDrive}), 32'h18, "halt pins");
        rd(ADR_STAT, 32'h1, 32'h1);
        xfer(1'b1, ADR_CTRL, 32'h0, 4'he);
        wt(4);
        chk(32'(spindleHalt), 32'h1, "masked write");
        wr(ADR_CTRL, 32'h0);
        wr(8'h18, 32'hffffffff);
        rd(8'h18, 32'h0, 32'hffffffff);
        chk(32'({spindleHalt, brakeRelay}), 32'h0, "halt released");
        for (int i = 0; i < 4; i++) begin
            v = 32'($urandom_range(255, 0));
            c = ($urandom() & 32'h0c) | (32'(i % 2) << C_SEEK) | (32'h1 << C_PWR);
            wr(ADR_VEL, v);
            wr(ADR_CTRL, c);
            wt(3);
            chk(32'({seekMode, evenPolarity, oddPolarity}), 32'({c[C_SEEK], c[C_EVEN], c[C_ODD]}),
                "mode pins");
            chk(32'(velocityCmd), c[C_SEEK] ? v : 32'h0, "velocity");
            chk(32'({servoEnable, lockRelease}), 32'h0, "servo locked");
        end
        wr(ADR_MASK, 32'h1 << I_XING);
        wr(ADR_CTRL, (32'h1 << C_SEEK) | (32'h1 << C_CLRTRK));
        n = $urandom_range(8, 3);
        for (int i = 0; i < n; i++) peak();
        rd(ADR_TRK, 32'(n), 32'hffff);
        chk(32'(irq), 32'h1, "crossing irq");
        wr(ADR_IRQ, 32'h1 << I_XING);
        wt(3);
        chk(32'(irq), 32'h0, "irq cleared");
        wr(ADR_CTRL, 32'h0);
        peak();
        rd(ADR_TRK, 32'(n), 32'hffff);
        wr(ADR_CTRL, (32'h1 << C_SEEK) | (32'h1 << C_DIR));
        peak();
        rd(ADR_TRK, 32'(n - 1), 32'hffff);
        wr(ADR_MASK, 32'h0);
        trkZeroReq <= 1'b1;
        wt(6);
        chk(32'({trkZeroOutN, irq}), 32'h0, "marker masked");
        rd(ADR_STAT, 32'h40, 32'h40);
        wr(ADR_MASK, 32'h1 << I_TRK0);
        wt(3);
        chk(32'(irq), 32'h1, "marker irq");
        wr(ADR_IRQ, 32'h1 << I_TRK0);
        trkZeroReq <= 1'b0;
        wt(6);
        chk(32'({trkZeroOutN, irq}), 32'h2, "marker gone");
        end_sim();
    end
endmodule
